// ==== common/gpr_cfg.svh ====
// gpio register bank constants: offsets, field layout, resets, codes
// assumes one 32-bit word per register on a byte-addressed bus
`ifndef GPR_CFG_SVH
`define GPR_CFG_SVH

`define GPR_NUM_IO 26
`define GPR_ADDR_W 8
`define GPR_IO_MASK 32'h03ffffff

`define GPR_OFF_DATA 8'h00
`define GPR_OFF_DIR 8'h04
`define GPR_OFF_SENSE 8'h10
`define GPR_OFF_BOTH 8'h14
`define GPR_OFF_POL 8'h18
`define GPR_OFF_UNMASK 8'h1c
`define GPR_OFF_RAW 8'h20
`define GPR_OFF_MASKED 8'h24
`define GPR_OFF_PCLR 8'h28
`define GPR_OFF_FUNC0 8'h2c
`define GPR_OFF_FUNC1 8'h30
`define GPR_OFF_FUNC2 8'h34
`define GPR_OFF_FUNC3 8'h38
`define GPR_OFF_OSET 8'h3c
`define GPR_OFF_OCLR 8'h40
`define GPR_OFF_ROUTE 8'h44

`define GPR_FUNC_W 3
`define GPR_FUNC_STRIDE 4
`define GPR_FUNC_PER_REG 8
`define GPR_FUNC_MASK 32'h77777777
`define GPR_FUNC3_MASK 32'h00000077
`define GPR_FUNC0_RST 32'h00000000
`define GPR_FUNC1_RST 32'h00000110
`define GPR_FUNC2_RST 32'h00000000
`define GPR_FUNC3_RST 32'h00000000
`define GPR_ROUTE_RST 32'h00000000

`define GPR_FUNC_GPIO 3'h0
`define GPR_TMODE_CAP_DUAL 3'h2
`define GPR_TMODE_CAP_SINGLE 3'h4

`define GPR_RESP_OKAY 2'h0
`define GPR_RESP_SLVERR 2'h2

`endif

// ==== common/gpr_pkg.sv ====
// gpio register bank types
// assumes gpr_cfg.svh for every numeric constant
package gpr_pkg;

    typedef logic [2:0] gpr_func_t;
    typedef logic [1:0] gpr_resp_t;
    typedef logic [31:0] gpr_word_t;

    // timer input routing word, one pin index per timer input
    typedef struct packed {
        logic [7:0] second_b;
        logic [7:0] second_a;
        logic [7:0] first_b;
        logic [7:0] first_a;
    } gpr_route_s;

    // the two inputs of one multi-function timer
    typedef struct packed {
        logic pin_b;
        logic pin_a;
    } gpr_tpins_s;

endpackage

// ==== rtl/gpr_top.sv ====
// gpio register bank: pin interrupts, pin functions, output data,
// timer input routing, reached as an axi4-lite slave
// assumes io_in comes from pads, timer modes from logic on aclk
`timescale 1ns/100ps
`include "gpr_cfg.svh"

// Summary of operation
// - masked pending word, read only, resets zero
// - ones written to pending clear drop raw
// - cleared unmasked bit leaves masked pending too
// - first function word: io0..io7, 4-bit stride
// - second function word, io9/io10 reset one
// - third function word: io16..io23, zero reset
// - fourth function word: io24, io25 only
// - set register ones raise gpio data bits
// - clear register ones drop gpio data bits
// - route word holds four 8-bit pin fields
// - field value is the selected pin index
// - routing applies only in capture modes
// - raw pending set on matching sense event
// - masked pending is unmask and raw
// - data drives gpio outputs, reads pin value
module gpr_top #(
    parameter int NUM_IO = `GPR_NUM_IO
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`GPR_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output gpr_pkg::gpr_resp_t s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`GPR_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output gpr_pkg::gpr_word_t s_axi_rdata,
    output gpr_pkg::gpr_resp_t s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_IO-1:0] io_in,
    output logic [NUM_IO-1:0] io_out,
    output logic [NUM_IO-1:0] io_oe,
    output gpr_pkg::gpr_func_t [NUM_IO-1:0] pin_func,
    input wire gpr_pkg::gpr_func_t timer_mode_first,
    input wire gpr_pkg::gpr_func_t timer_mode_second,
    output gpr_pkg::gpr_tpins_s timer_first,
    output gpr_pkg::gpr_tpins_s timer_second,
    output logic irq
);
    import gpr_pkg::*;

    localparam int PAD = 32 - NUM_IO;
    localparam logic [31:0] IO_MASK = `GPR_IO_MASK;

    ////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] s);
        merge = (old & ~strb_mask(s)) | (nw & strb_mask(s));
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            `GPR_OFF_DATA, `GPR_OFF_DIR, `GPR_OFF_SENSE, `GPR_OFF_BOTH,
            `GPR_OFF_POL, `GPR_OFF_UNMASK, `GPR_OFF_RAW, `GPR_OFF_MASKED,
            `GPR_OFF_PCLR, `GPR_OFF_FUNC0, `GPR_OFF_FUNC1, `GPR_OFF_FUNC2,
            `GPR_OFF_FUNC3, `GPR_OFF_OSET, `GPR_OFF_OCLR,
            `GPR_OFF_ROUTE: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    // out-of-range index selects nothing rather than aliasing a pin
    function automatic logic pick(input logic [7:0] sel,
                                  input logic [31:0] pins);
        if (sel < 8'(NUM_IO)) begin
            pick = pins[sel[4:0]];
        end else begin
            pick = 1'b0;
        end
    endfunction

    function automatic logic is_capture(input gpr_func_t m);
        is_capture = (m == `GPR_TMODE_CAP_DUAL) ||
                     (m == `GPR_TMODE_CAP_SINGLE);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // state

    logic [31:0] data;
    logic [31:0] dir;
    logic [31:0] sense_type_sel;
    logic [31:0] both_edge_sel;
    logic [31:0] polarity_sel;
    logic [31:0] unmask_bits;
    logic [31:0] raw_pending;
    logic [31:0] func [4];
    gpr_route_s timer_input_route;

    logic [NUM_IO-1:0] sync1;
    logic [NUM_IO-1:0] sync2;
    logic [NUM_IO-1:0] prev;

    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    ////////////////////////////////////////////////////////////////////
    // pin synchroniser; sync1 feeds only sync2

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= '0;
            sync2 <= '0;
            prev <= '0;
        end else begin
            sync1 <= io_in;
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    logic [31:0] pin32;
    logic [31:0] rise32;
    logic [31:0] fall32;
    assign pin32 = {{PAD{1'b0}}, sync2};
    assign rise32 = {{PAD{1'b0}}, sync2 & ~prev};
    assign fall32 = {{PAD{1'b0}}, ~sync2 & prev};

    ////////////////////////////////////////////////////////////////////
    // pin functions

    gpr_func_t [NUM_IO-1:0] func_w;
    logic [31:0] gpio32;

    always_comb begin
        gpio32 = '0;
        for (int i = 0; i < NUM_IO; i++) begin
            func_w[i] = func[i / `GPR_FUNC_PER_REG]
                [(i % `GPR_FUNC_PER_REG) * `GPR_FUNC_STRIDE +: `GPR_FUNC_W];
            gpio32[i] = (func_w[i] == `GPR_FUNC_GPIO);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // write channel

    logic wr_fire;
    logic [7:0] wa;
    logic [31:0] wbits;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wa = {aw_addr[7:2], 2'b00};
    assign wbits = w_data & strb_mask(w_strb);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else begin
            if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (!aw_held && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else begin
            if (wr_fire) begin
                w_held <= 1'b0;
            end
            if (!w_held && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `GPR_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_mapped(wa) ? `GPR_RESP_OKAY
                                         : `GPR_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // configuration registers; reserved bits are not stored

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir <= '0;
            sense_type_sel <= '0;
            both_edge_sel <= '0;
            polarity_sel <= '0;
            unmask_bits <= '0;
        end else if (wr_fire) begin
            case (wa)
                `GPR_OFF_DIR: dir <= merge(dir, w_data, w_strb) & IO_MASK;
                `GPR_OFF_SENSE:
                    sense_type_sel <= merge(sense_type_sel, w_data, w_strb)
                                      & IO_MASK;
                `GPR_OFF_BOTH:
                    both_edge_sel <= merge(both_edge_sel, w_data, w_strb)
                                     & IO_MASK;
                `GPR_OFF_POL:
                    polarity_sel <= merge(polarity_sel, w_data, w_strb)
                                    & IO_MASK;
                `GPR_OFF_UNMASK:
                    unmask_bits <= merge(unmask_bits, w_data, w_strb)
                                   & IO_MASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            func[0] <= `GPR_FUNC0_RST;
            func[1] <= `GPR_FUNC1_RST;
            func[2] <= `GPR_FUNC2_RST;
            func[3] <= `GPR_FUNC3_RST;
            timer_input_route <= `GPR_ROUTE_RST;
        end else if (wr_fire) begin
            case (wa)
                `GPR_OFF_FUNC0: func[0] <= merge(func[0], w_data, w_strb)
                                           & `GPR_FUNC_MASK;
                `GPR_OFF_FUNC1: func[1] <= merge(func[1], w_data, w_strb)
                                           & `GPR_FUNC_MASK;
                `GPR_OFF_FUNC2: func[2] <= merge(func[2], w_data, w_strb)
                                           & `GPR_FUNC_MASK;
                `GPR_OFF_FUNC3: func[3] <= merge(func[3], w_data, w_strb)
                                           & `GPR_FUNC3_MASK;
                `GPR_OFF_ROUTE: timer_input_route <=
                    merge(timer_input_route, w_data, w_strb);
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // output data; set/clear touch only pins in gpio function

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data <= '0;
        end else if (wr_fire && wa == `GPR_OFF_DATA) begin
            data <= merge(data, w_data, w_strb) & IO_MASK;
        end else if (wr_fire && wa == `GPR_OFF_OSET) begin
            data <= data | (wbits & gpio32 & IO_MASK);
        end else if (wr_fire && wa == `GPR_OFF_OCLR) begin
            data <= data & ~(wbits & gpio32);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            io_out <= '0;
            io_oe <= '0;
            pin_func <= '0;
        end else begin
            io_out <= data[NUM_IO-1:0];
            io_oe <= dir[NUM_IO-1:0] & gpio32[NUM_IO-1:0];
            pin_func <= func_w;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin interrupts

    logic [31:0] hit32;
    logic [31:0] clr32;
    logic [31:0] masked_pending;

    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (sense_type_sel[i]) begin
                hit32[i] = polarity_sel[i] ? pin32[i] : ~pin32[i];
            end else if (both_edge_sel[i]) begin
                hit32[i] = rise32[i] | fall32[i];
            end else begin
                hit32[i] = polarity_sel[i] ? rise32[i] : fall32[i];
            end
        end
    end

    // writes of zero leave raw bits alone
    assign clr32 = (wr_fire && wa == `GPR_OFF_PCLR) ? wbits : '0;
    assign masked_pending = raw_pending & unmask_bits;

    // a new event in the clear cycle survives: set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            raw_pending <= '0;
        end else begin
            raw_pending <= ((raw_pending & ~clr32) | hit32)
                           & IO_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |masked_pending;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // timer input routing, live only in capture modes

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_first <= '0;
            timer_second <= '0;
        end else begin
            timer_first.pin_a <= is_capture(timer_mode_first) &&
                pick(timer_input_route.first_a, pin32);
            timer_first.pin_b <= is_capture(timer_mode_first) &&
                pick(timer_input_route.first_b, pin32);
            timer_second.pin_a <= is_capture(timer_mode_second) &&
                pick(timer_input_route.second_a, pin32);
            timer_second.pin_b <= is_capture(timer_mode_second) &&
                pick(timer_input_route.second_b, pin32);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read channel

    logic [7:0] ra;
    logic [31:0] rd_word;
    assign ra = {s_axi_araddr[7:2], 2'b00};

    always_comb begin
        case (ra)
            `GPR_OFF_DATA: rd_word = pin32;
            `GPR_OFF_DIR: rd_word = dir;
            `GPR_OFF_SENSE: rd_word = sense_type_sel;
            `GPR_OFF_BOTH: rd_word = both_edge_sel;
            `GPR_OFF_POL: rd_word = polarity_sel;
            `GPR_OFF_UNMASK: rd_word = unmask_bits;
            `GPR_OFF_RAW: rd_word = raw_pending;
            `GPR_OFF_MASKED: rd_word = masked_pending;
            `GPR_OFF_FUNC0: rd_word = func[0];
            `GPR_OFF_FUNC1: rd_word = func[1];
            `GPR_OFF_FUNC2: rd_word = func[2];
            `GPR_OFF_FUNC3: rd_word = func[3];
            `GPR_OFF_ROUTE: rd_word = timer_input_route;
            default: rd_word = '0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `GPR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= is_mapped(ra) ? `GPR_RESP_OKAY
                                         : `GPR_RESP_SLVERR;
        end else begin
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

// ==== bench/gpr_properties.sv ====
// checker for the gpio register bank, watching top-level ports only
// assumes it is bound into gpr_top after the module definition
`timescale 1ns/100ps
`include "gpr_cfg.svh"
module gpr_properties #(
    parameter int NUM_IO = `GPR_NUM_IO
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`GPR_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire gpr_pkg::gpr_word_t s_axi_rdata,
    input wire gpr_pkg::gpr_resp_t s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_IO-1:0] io_oe,
    input wire gpr_pkg::gpr_func_t [NUM_IO-1:0] pin_func,
    input wire gpr_pkg::gpr_func_t timer_mode_first,
    input wire gpr_pkg::gpr_tpins_s timer_first,
    input wire logic irq
);
    import gpr_pkg::*;
    logic cap1;
    logic ar_hs;
    assign cap1 = timer_mode_first == `GPR_TMODE_CAP_DUAL
        || timer_mode_first == `GPR_TMODE_CAP_SINGLE;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////
    a_reset_quiet: assert property (
        $rose(aresetn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs active right after reset");
    a_b_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_r_holds: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_write_blocked: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_read_answer: assert property (
        ar_hs |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered one cycle after address");
    a_unmapped_read: assert property (
        ar_hs && s_axi_araddr == 8'h08 |=>
        s_axi_rresp == `GPR_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_clear_reads_zero: assert property (
        ar_hs && s_axi_araddr == `GPR_OFF_PCLR |=> s_axi_rdata == 32'h0)
        else $error("pending clear read not zero");
    a_oe_needs_gpio: assert property (
        io_oe[0] && $stable(pin_func[0]) |-> pin_func[0] == `GPR_FUNC_GPIO)
        else $error("pin driven outside gpio function");
    a_timer_idle: assert property (
        !cap1 ##1 !cap1 |-> timer_first == 2'h0)
        else $error("timer input routed outside capture mode");
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp != 2'h0);
    c_irq: cover property ($rose(irq) ##[1:200] $fell(irq));
    c_route: cover property (timer_first.pin_a);
endmodule
bind gpr_top gpr_properties #(.NUM_IO(NUM_IO)) u_props (.*);

// ==== bench/gpr_pad_model.sv ====
// pads and outside circuitry facing the gpio pins
// assumes ext carries the level the outside world puts on undriven pins
`timescale 1ns/100ps
module gpr_pad_model (
    input wire logic [25:0] io_out,
    input wire logic [25:0] io_oe,
    input wire logic [25:0] ext,
    output logic [25:0] io_in
);
    // a driven pad reads back its own level, others the outside level
    assign io_in = (io_oe & io_out) | (~io_oe & ext);
endmodule

// ==== bench/gpr_top_test.sv ====
// self-checking bench for the gpio register bank over axi4-lite
// assumes gpr_pad_model closes the pins and the bench sets timer modes
`timescale 1ns/100ps
`include "gpr_cfg.svh"
module gpr_top_test;
    import gpr_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, irq;
    gpr_resp_t s_axi_bresp, s_axi_rresp;
    gpr_word_t s_axi_rdata;
    logic [25:0] io_in, io_out, io_oe;
    logic [25:0] ext = 26'h0;
    gpr_func_t [25:0] pin_func;
    gpr_func_t timer_mode_first = 3'h0, timer_mode_second = 3'h0;
    gpr_tpins_s timer_first, timer_second;
    int errors = 0, n_compared = 0;
    logic [7:0] fa [4] = '{8'h2c, 8'h30, 8'h34, 8'h38};
    logic [31:0] fr [4] = '{32'h0, 32'h110, 32'h0, 32'h0};
    logic [31:0] fm [4] = '{32'h77777777, 32'h77777777, 32'h77777777, 32'h77};
    always #4 aclk = ~aclk;
    gpr_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .io_in, .io_out,
        .io_oe, .pin_func, .timer_mode_first, .timer_mode_second,
        .timer_first, .timer_second, .irq);
    gpr_pad_model pads (.io_out, .io_oe, .ext, .io_in);
    ////////////////////////////////////////////////////////////////////
    task automatic final_report;
        if (errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tmo(input int k);
        if (k == 64) begin
            errors++;
            $display("BAD %0t no bus answer", $time);
            final_report();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input gpr_resp_t er = 2'h0,
                      input logic [3:0] st = 4'hf);
        int k;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (k = 0; k < 64; k++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'h0;
        tmo(k);
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input gpr_resp_t er = 2'h0);
        int k;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (k = 0; k < 64; k++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'h0;
        tmo(k);
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        for (int i = 0; i < 4; i++) rd(fa[i], fr[i]);
        rd(8'h44, 32'h0);
        rd(8'h24, 32'h0);
        rd(8'h28, 32'h0);
        wr(8'h08, 32'h1, 2'h2);
        rd(8'h08, 32'h0, 2'h2);
        wr(8'h04, 32'h20f);
        // reserved bits written as zero, as software must
        for (int i = 0; i < 4; i++) begin
            wr(fa[i], fm[i]);
            rd(fa[i], fm[i]);
            wr(fa[i], 32'h0);
        end
        wr(8'h30, 32'h10);
        @(posedge aclk);
        chk({29'h0, pin_func[9]}, 32'h1);
        chk({6'h0, io_oe}, 32'hf);
        wr(8'h00, 32'h0);
        wr(8'h3c, 32'h205);
        repeat (3) @(posedge aclk);
        chk({6'h0, io_out}, 32'h5);
        rd(8'h00, 32'h5);
        wr(8'h40, 32'h201);
        repeat (2) @(posedge aclk);
        chk({6'h0, io_out}, 32'h4);
        wr(8'h00, 32'h200);
        wr(8'h40, 32'h200);
        repeat (2) @(posedge aclk);
        chk({6'h0, io_out}, 32'h200);
        // pins 0 and 2 fell above, caught by the default falling sense
        rd(8'h20, 32'h5);
        wr(8'h28, 32'h5);
        wr(8'h18, 32'h100000);
        wr(8'h1c, 32'h100000);
        ext <= 26'h100000;
        repeat (6) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        rd(8'h20, 32'h100000);
        rd(8'h24, 32'h100000);
        wr(8'h28, 32'h0);
        rd(8'h20, 32'h100000);
        wr(8'h1c, 32'h0);
        rd(8'h24, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(8'h1c, 32'h100000);
        wr(8'h28, 32'h100000);
        rd(8'h20, 32'h0);
        rd(8'h24, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(8'h10, 32'h100000);
        repeat (3) @(posedge aclk);
        rd(8'h20, 32'h100000);
        wr(8'h44, 32'hffffffff, 2'h0, 4'h1);
        rd(8'h44, 32'hff);
        // 0x1a lies past the last pin, so that input must stay low
        wr(8'h44, 32'h191a0514);
        rd(8'h44, 32'h191a0514);
        ext <= 26'h2100000;
        for (int m = 0; m < 8; m++) begin
            timer_mode_first <= m[2:0];
            timer_mode_second <= m[2:0];
            repeat (4) @(posedge aclk);
            chk({30'h0, timer_first}, {31'h0, m == 2 || m == 4});
            chk({30'h0, timer_second}, {30'h0, m == 2 || m == 4, 1'h0});
        end
        final_report();
    end
endmodule
